// ### rtl/cic_consts.vh
// Constants for the core interrupt controller
`ifndef CIC_CONSTS_VH
`define CIC_CONSTS_VH
// Register indices (printed offsets not all multiples of four)
`define CIC_IDX_SENSE_A 8'h37
`define CIC_IDX_SENSE_B 8'h3d
`define CIC_IDX_CTRL 8'h40
`define CIC_IDX_STATUS 8'h41
`define CIC_IDX_VECTOR 8'h42
`define CIC_IDX_WAKE 8'h43
`define CIC_SENSE_A_RESET 8'h00
`define CIC_SENSE_B_RESET 8'h00
`define CIC_SENSE_A_MASK 8'h3f
`define CIC_SENSE_B_MASK 8'h0f
// Sensitivity encodings
`define CIC_SENS_FALL_LOW 2'h0
`define CIC_SENS_RISE 2'h1
`define CIC_SENS_FALL 2'h2
`define CIC_SENS_BOTH 2'h3
// Control register bit positions
`define CIC_CTRL_TRAP_BIT 0
`define CIC_CTRL_RETURN_BIT 1
`define CIC_CTRL_SETMASK_BIT 2
`define CIC_CTRL_CLRMASK_BIT 3
// Vector addresses
`define CIC_VEC_RESET 16'hfffe
`define CIC_VEC_TRAP 16'hfffc
`define CIC_VEC_AWU 16'hfffa
`define CIC_VEC_EXT0 16'hfff8
`define CIC_VEC_EXT1 16'hfff6
`define CIC_VEC_EXT2 16'hfff4
`define CIC_VEC_EXT3 16'hfff0
`define CIC_VEC_EXT4 16'hffee
`define CIC_VEC_AT_CMP 16'hffea
`define CIC_VEC_AT_OVF 16'hffe8
`define CIC_VEC_LT_CAP 16'hffe6
`define CIC_VEC_LT_TB 16'hffe4
// Low-power modes
`define CIC_LP_RUN 3'h0
`define CIC_LP_WAIT 3'h1
`define CIC_LP_HALT 3'h2
`define CIC_LP_ACTIVE_HALT 3'h3
`define CIC_LP_AUTO_WAKE 3'h4
`endif

// ### rtl/cic_ext_line.v
// One external interrupt line: sensitivity detect and pending latch
`timescale 1ns/10ps
`include "cic_consts.vh"
module cic_ext_line (
    // Clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // Line and control
    input wire i_level,
    input wire i_block_n,
    input wire [1:0] i_sense,
    input wire i_sense_change,
    input wire i_ack,
    // Status
    output wire o_pending,
    output reg o_fall_seen
);
    reg prev_level;
    reg latch;
    wire rise;
    wire fall;
    reg edge_hit;
    reg low_hold;
    assign rise = i_level & ~prev_level & i_block_n; // RULE9
    assign fall = ~i_level & prev_level;
    always @* begin
        edge_hit = 1'b0;
        low_hold = 1'b0;
        case (i_sense)
            `CIC_SENS_FALL_LOW: begin
                edge_hit = fall;
                low_hold = ~i_level; // RULE24
            end
            `CIC_SENS_RISE: edge_hit = rise;
            `CIC_SENS_FALL: edge_hit = fall;
            `CIC_SENS_BOTH: edge_hit = rise | fall; // RULE18
            default: edge_hit = 1'b0;
        endcase
    end
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev_level <= 1'b1;
            latch <= 1'b0;
            o_fall_seen <= 1'b0;
        end else begin
            prev_level <= i_level;
            // Remembers whether the latched request came from a fall
            if (i_sense_change) begin
                latch <= 1'b0; // RULE22
                o_fall_seen <= 1'b0;
            end else if (edge_hit) begin
                latch <= 1'b1; // RULE8
                o_fall_seen <= fall; // RULE15
            end else if (i_ack) begin
                latch <= 1'b0; // RULE8
                o_fall_seen <= 1'b0;
            end
        end
    end
    assign o_pending = (latch | low_hold) & i_block_n; // RULE9
endmodule // cic_ext_line

// ### rtl/cic_core.v
// Core interrupt controller: priority, entry/return, wakeup, registers
// Summary of operation
// RULE1 - Maskable requests are taken only while the global mask is clear.
// RULE2 - After reset the global mask is set, all interrupts disabled.
// RULE3 - Entry: finish instruction, stack registers, set mask, load vector.
// RULE4 - Return restores registers, clears the mask, resumes program.
// RULE5 - Fixed priority: reset, trap, then sources by ascending number.
// RULE6 - Any source wakes wait; only designated sources wake halt. The code keeps auto wakeup (source 0) from waking wait.
// RULE7 - Software trap enters its sequence whatever the mask.
// RULE8 - Edge requests latch and clear on entry to their routine.
// RULE9 - Low level on a combined enabled pin blocks its line's request.
// RULE10 - Peripheral flag interrupts only with mask clear and enable set.
// RULE11 - Clearing a peripheral flag discards its pending request.
// RULE12 - External line vectors FFF8, FFF6, FFF4, FFF0, FFEE.
// RULE13 - Timer compare FFEA, overflow FFE8; compare never wakes halt.
// RULE14 - Capture FFE6, time base FFE4; capture never wakes halt.
// RULE15 - Falling edge on line two never wakes any halt mode.
// RULE16 - Line four wakes wait and active halt; auto wakeup its mode only.
// RULE17 - Timer overflow and time base wake active halt only.
// RULE18 - Sensitivity: 00 fall and low, 01 rise, 10 fall, 11 both.
// RULE19 - Register A: line two 5:4, one 3:2, zero 1:0; top bits zero.
// RULE20 - Register B: line four 3:2, line three 1:0; upper bits zero.
// RULE21 - Sensitivity writes accepted only while the global mask is set.
// RULE22 - Changing a line's sensitivity clears its pending request.
// RULE23 - Software sets line four to 01 before halt modes.
// RULE24 - Fall-and-low mode keeps requesting while the pin stays low.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
`include "cic_consts.vh"
module cic_core #(
    parameter NUM_EXT = 5
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // Avalon-MM slave
    input wire [9:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // External lines and combined-pin blocking
    input wire [NUM_EXT-1:0] i_ext_level,
    input wire [NUM_EXT-1:0] i_ext_block_n,
    // Peripheral flags and enables: awu, at_cmp, at_ovf, lt_cap, lt_tb
    input wire [4:0] i_periph_flag,
    input wire [4:0] i_periph_enable,
    // CPU sequencer
    input wire i_instr_end,
    input wire i_trap_instr,
    input wire i_return_instr,
    input wire i_stack_done,
    input wire i_restore_done,
    input wire [2:0] i_lp_mode,
    output reg o_push_regs,
    output reg o_pop_regs,
    output reg o_load_vector,
    output reg [15:0] o_vector,
    output reg o_global_mask,
    output reg o_wakeup,
    output reg [NUM_EXT-1:0] o_ext_ack
);
    localparam ST_IDLE = 4'h1;
    localparam ST_PUSH = 4'h2;
    localparam ST_LOAD = 4'h4;
    localparam ST_POP = 4'h8;
    // Source numbers 0..13; bit positions of the pending word
    localparam NSRC = 14;
    reg [3:0] state;
    reg [7:0] sense_a;
    reg [7:0] sense_b;
    reg rd_hold;
    reg [3:0] sel_src;
    reg sel_trap;
    reg [NSRC-1:0] pend;
    reg [NSRC-1:0] take;
    reg [3:0] next_src;
    reg next_hit;
    reg trap_req;
    wire [NUM_EXT-1:0] ext_pend;
    wire [NUM_EXT-1:0] ext_fall;
    wire [9:0] sense_all;
    wire [9:0] next_sense_a;
    wire [9:0] next_sense_b;
    wire [9:0] sense_wr;
    wire [7:0] idx;
    wire wr_a;
    wire wr_b;
    wire wr_ctrl;
    genvar g;

    function [15:0] vec_of;
        input [3:0] src;
        begin
            case (src)
                4'h0: vec_of = `CIC_VEC_AWU;
                4'h1: vec_of = `CIC_VEC_EXT0; // RULE12
                4'h2: vec_of = `CIC_VEC_EXT1; // RULE12
                4'h3: vec_of = `CIC_VEC_EXT2; // RULE12
                4'h5: vec_of = `CIC_VEC_EXT3; // RULE12
                4'h6: vec_of = `CIC_VEC_EXT4; // RULE12
                4'h8: vec_of = `CIC_VEC_AT_CMP; // RULE13
                4'h9: vec_of = `CIC_VEC_AT_OVF; // RULE13
                4'ha: vec_of = `CIC_VEC_LT_CAP; // RULE14
                4'hb: vec_of = `CIC_VEC_LT_TB; // RULE14
                default: vec_of = `CIC_VEC_RESET;
            endcase
        end
    endfunction

    // Writes land at once; a read waits one cycle for its registered data
    assign o_avs_waitrequest = i_avs_read & ~rd_hold;
    assign idx = i_avs_address[9:2];
    assign wr_a = i_avs_write && idx == `CIC_IDX_SENSE_A && o_global_mask;
    assign wr_b = i_avs_write && idx == `CIC_IDX_SENSE_B && o_global_mask;
    assign wr_ctrl = i_avs_write && idx == `CIC_IDX_CTRL;
    assign sense_all = {sense_b[3:0], sense_a[5:0]};
    assign next_sense_a = {4'h0, i_avs_writedata[5:0]};
    assign next_sense_b = {i_avs_writedata[3:0], 6'h00};
    // Write of a changed field clears that line's latch
    assign sense_wr[5:0] = {6{wr_a}} &
        (next_sense_a[5:0] ^ sense_all[5:0]); // RULE22
    assign sense_wr[9:6] = {4{wr_b}} &
        (next_sense_b[9:6] ^ sense_all[9:6]); // RULE22

    generate
        for (g = 0; g < NUM_EXT; g = g + 1) begin : gen_line
            cic_ext_line u_line (
                .i_clk(i_clk),
                .i_reset_n(i_reset_n),
                .i_level(i_ext_level[g]),
                .i_block_n(i_ext_block_n[g]),
                .i_sense(sense_all[2*g+1:2*g]), // RULE19 RULE20
                .i_sense_change(|sense_wr[2*g+1:2*g]),
                .i_ack(o_ext_ack[g]),
                .o_pending(ext_pend[g]),
                .o_fall_seen(ext_fall[g])
            );
        end
    endgenerate

    // Pending word by source number
    always @* begin
        pend = {NSRC{1'b0}};
        pend[0] = i_periph_flag[0] & i_periph_enable[0]; // RULE10 RULE11
        pend[1] = ext_pend[0];
        pend[2] = ext_pend[1];
        pend[3] = ext_pend[2];
        pend[5] = ext_pend[3];
        pend[6] = ext_pend[4];
        pend[8] = i_periph_flag[1] & i_periph_enable[1]; // RULE10
        pend[9] = i_periph_flag[2] & i_periph_enable[2]; // RULE10
        pend[10] = i_periph_flag[3] & i_periph_enable[3]; // RULE10
        pend[11] = i_periph_flag[4] & i_periph_enable[4]; // RULE10
    end

    // Lowest source number wins
    integer k;
    always @* begin
        next_src = 4'h0;
        next_hit = 1'b0;
        for (k = NSRC - 1; k >= 0; k = k - 1) begin
            if (pend[k]) begin
                next_src = k[3:0]; // RULE5
                next_hit = 1'b1;
            end
        end
    end

    // Wakeup qualification per low-power mode
    always @* begin
        take = {NSRC{1'b0}};
        case (i_lp_mode)
            `CIC_LP_WAIT: begin
                take = pend; // RULE6
                take[0] = 1'b0; // RULE16
            end
            `CIC_LP_HALT: begin
                take[1] = pend[1];
                take[2] = pend[2];
                take[3] = pend[3] & ~ext_fall[2]; // RULE15
                take[5] = pend[5];
            end
            `CIC_LP_ACTIVE_HALT: begin
                take[1] = pend[1];
                take[2] = pend[2];
                take[3] = pend[3] & ~ext_fall[2]; // RULE15
                take[5] = pend[5];
                take[6] = pend[6]; // RULE16
                take[9] = pend[9]; // RULE17
                take[11] = pend[11]; // RULE17
            end
            `CIC_LP_AUTO_WAKE: begin
                take[0] = pend[0]; // RULE16
                take[1] = pend[1];
                take[2] = pend[2];
                take[3] = pend[3] & ~ext_fall[2]; // RULE15
                take[5] = pend[5];
            end
            default: take = {NSRC{1'b0}};
        endcase
    end

    // Entry and return sequencer
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            o_global_mask <= 1'b1; // RULE2
            o_push_regs <= 1'b0;
            o_pop_regs <= 1'b0;
            o_load_vector <= 1'b0;
            o_vector <= `CIC_VEC_RESET;
            o_ext_ack <= {NUM_EXT{1'b0}};
            o_wakeup <= 1'b0;
            sel_src <= 4'h0;
            sel_trap <= 1'b0;
            trap_req <= 1'b0;
        end else begin
            o_load_vector <= 1'b0;
            o_ext_ack <= {NUM_EXT{1'b0}};
            o_wakeup <= |take;
            if (i_trap_instr || (wr_ctrl &&
                i_avs_writedata[`CIC_CTRL_TRAP_BIT]))
                trap_req <= 1'b1;
            if (wr_ctrl && i_avs_writedata[`CIC_CTRL_SETMASK_BIT])
                o_global_mask <= 1'b1;
            else if (wr_ctrl && i_avs_writedata[`CIC_CTRL_CLRMASK_BIT])
                o_global_mask <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (i_instr_end && trap_req) begin
                        sel_trap <= 1'b1; // RULE7
                        trap_req <= 1'b0;
                        o_push_regs <= 1'b1; // RULE3
                        state <= ST_PUSH;
                    end else if (i_instr_end && next_hit &&
                                 !o_global_mask) begin // RULE1
                        sel_trap <= 1'b0;
                        sel_src <= next_src; // RULE5
                        o_push_regs <= 1'b1; // RULE3
                        state <= ST_PUSH;
                    end else if (i_return_instr || (wr_ctrl &&
                        i_avs_writedata[`CIC_CTRL_RETURN_BIT])) begin
                        o_pop_regs <= 1'b1; // RULE4
                        state <= ST_POP;
                    end
                end
                ST_PUSH: begin
                    if (i_stack_done) begin
                        o_push_regs <= 1'b0;
                        o_global_mask <= 1'b1; // RULE3
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    o_vector <= sel_trap ? `CIC_VEC_TRAP : vec_of(sel_src);
                    o_load_vector <= 1'b1; // RULE3
                    if (!sel_trap) begin
                        case (sel_src)
                            4'h1: o_ext_ack[0] <= 1'b1; // RULE8
                            4'h2: o_ext_ack[1] <= 1'b1;
                            4'h3: o_ext_ack[2] <= 1'b1;
                            4'h5: o_ext_ack[3] <= 1'b1;
                            4'h6: o_ext_ack[4] <= 1'b1;
                            default: o_ext_ack <= {NUM_EXT{1'b0}};
                        endcase
                    end
                    state <= ST_IDLE;
                end
                ST_POP: begin
                    if (i_restore_done) begin
                        o_pop_regs <= 1'b0;
                        o_global_mask <= 1'b0; // RULE4
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Sensitivity registers
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sense_a <= `CIC_SENSE_A_RESET;
            sense_b <= `CIC_SENSE_B_RESET;
        end else begin
            if (wr_a)
                sense_a <= i_avs_writedata[7:0] & `CIC_SENSE_A_MASK; // RULE21
            if (wr_b)
                sense_b <= i_avs_writedata[7:0] & `CIC_SENSE_B_MASK; // RULE21
        end
    end

    // High in the cycle after the one wait cycle of a read, when it is accepted
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            rd_hold <= 1'b0;
        else
            rd_hold <= o_avs_waitrequest;
    end

    // Read data registered on the wait cycle, standing at the accept edge
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_avs_readdata <= 32'h00000000;
        end else if (o_avs_waitrequest) begin
            case (idx)
                `CIC_IDX_SENSE_A: o_avs_readdata <= {24'h0, sense_a};
                `CIC_IDX_SENSE_B: o_avs_readdata <= {24'h0, sense_b};
                `CIC_IDX_CTRL: o_avs_readdata <= {31'h0, o_global_mask};
                `CIC_IDX_STATUS:
                    o_avs_readdata <= {14'h0, state, pend};
                `CIC_IDX_VECTOR: o_avs_readdata <= {16'h0, o_vector};
                `CIC_IDX_WAKE: o_avs_readdata <= {18'h0, take};
                default: o_avs_readdata <= 32'h00000000;
            endcase
        end
    end
endmodule // cic_core

// ### tb/cic_core_sva.sv
// Concurrent checks on the core interrupt controller ports
`timescale 1ns/10ps
`include "cic_consts.vh"
module cic_core_sva #(
    parameter NUM_EXT = 5
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // Sequencer and source inputs
    input wire i_instr_end,
    input wire i_stack_done,
    input wire i_restore_done,
    input wire [2:0] i_lp_mode,
    input wire [4:0] i_periph_flag,
    input wire [4:0] i_periph_enable,
    // Design outputs
    input wire o_push_regs,
    input wire o_pop_regs,
    input wire o_load_vector,
    input wire [15:0] o_vector,
    input wire o_global_mask,
    input wire o_wakeup,
    input wire [NUM_EXT-1:0] o_ext_ack
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    sequence s_stacked;
        !o_push_regs && o_global_mask ##1 o_load_vector;
    endsequence
    sequence s_waiting;
        (i_lp_mode == `CIC_LP_WAIT && !o_global_mask
            && |(i_periph_flag[4:1] & i_periph_enable[4:1])) [*2];
    endsequence
    a_reset_mask: assert property (
        $rose(i_reset_n) |-> o_global_mask) else $error("mask clear");
    a_entry_cause: assert property (
        $rose(o_push_regs) |-> $past(i_instr_end)) else $error("early entry");
    a_stack_load: assert property (
        o_push_regs && i_stack_done |=> s_stacked) else $error("bad entry");
    a_return_mask: assert property (
        o_pop_regs && i_restore_done |=> !o_pop_regs && !o_global_mask)
        else $error("bad return");
    a_ack_one: assert property (
        |o_ext_ack |-> o_load_vector && $onehot(o_ext_ack))
        else $error("bad ack");
    a_vec_line0: assert property (
        o_load_vector |-> o_ext_ack[0] == (o_vector == `CIC_VEC_EXT0))
        else $error("line zero vector");
    a_vec_line3: assert property (
        o_load_vector |-> o_ext_ack[3] == (o_vector == `CIC_VEC_EXT3))
        else $error("line three vector");
    a_wait_wake: assert property (
        s_waiting |-> o_wakeup) else $error("no wake from wait");
endmodule // cic_core_sva
bind cic_core cic_core_sva #(.NUM_EXT(NUM_EXT)) i_sva (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_instr_end(i_instr_end),
    .i_stack_done(i_stack_done), .i_restore_done(i_restore_done),
    .i_lp_mode(i_lp_mode), .i_periph_flag(i_periph_flag),
    .i_periph_enable(i_periph_enable), .o_push_regs(o_push_regs),
    .o_pop_regs(o_pop_regs), .o_load_vector(o_load_vector),
    .o_vector(o_vector), .o_global_mask(o_global_mask),
    .o_wakeup(o_wakeup), .o_ext_ack(o_ext_ack));

// ### tb/cic_seq_model.sv
// Behavioural model of the CPU stack sequencer
`timescale 1ns/10ps
module cic_seq_model (
    // Clock and reset
    input wire i_clk,
    input wire i_reset_n,
    // Requests from the controller, stack delay select from the bench
    input wire i_push_regs,
    input wire i_pop_regs,
    input wire i_slow,
    // Completion pulses
    output reg o_stack_done,
    output reg o_restore_done
);
    reg [2:0] cnt;
    wire [2:0] dly = i_slow ? 3'h5 : 3'h0;
    // One done pulse per push or pop, after dly idle cycles
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt <= 3'h0;
            o_stack_done <= 1'b0;
            o_restore_done <= 1'b0;
        end else if (o_stack_done || o_restore_done) begin
            o_stack_done <= 1'b0;
            o_restore_done <= 1'b0;
            cnt <= 3'h0;
        end else if (i_push_regs || i_pop_regs) begin
            if (cnt == dly) begin
                o_stack_done <= i_push_regs;
                o_restore_done <= i_pop_regs;
            end else begin
                cnt <= cnt + 3'h1;
            end
        end
    end
endmodule // cic_seq_model

// ### tb/core_interrupt_controller_tb_top.sv
// Self-checking bench for the core interrupt controller
`timescale 1ns/10ps
`include "cic_consts.vh"
module core_interrupt_controller_tb_top;
    reg clk, rst_n = 1'b0, rd = 1'b0, wr_en = 1'b0, ie = 1'b0;
    reg trap = 1'b0, ret = 1'b0, slow = 1'b0;
    reg [9:0] adr = 10'h0;
    reg [31:0] wd = 32'h0;
    reg [4:0] lvl = 5'h1f, blk_n = 5'h1f, flag = 5'h0, ena = 5'h0;
    reg [2:0] lp = 3'h0;
    wire [31:0] rdata;
    wire [15:0] vec;
    wire [4:0] ack;
    wire wreq, push, pop, load, mask, wake, sd, rdn;
    integer n_errors = 0, checked = 0, n_load = 0, i;
    reg [15:0] last_vec;
    reg [15:0] pv [0:4] = '{`CIC_VEC_AWU, `CIC_VEC_AT_CMP,
        `CIC_VEC_AT_OVF, `CIC_VEC_LT_CAP, `CIC_VEC_LT_TB};
    // Wake table: mode, flag index, expected wake
    reg [2:0] md [0:7] = '{3'h1, 3'h2, 3'h3, 3'h2, 3'h4, 3'h2, 3'h2, 3'h3};
    reg [2:0] fi [0:7] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h0, 3'h0, 3'h3, 3'h4};
    reg ex [0:7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

    cic_core #(.NUM_EXT(5)) i_dut (.i_clk(clk), .i_reset_n(rst_n),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr_en),
        .i_avs_writedata(wd), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_ext_level(lvl), .i_ext_block_n(blk_n),
        .i_periph_flag(flag), .i_periph_enable(ena), .i_instr_end(ie),
        .i_trap_instr(trap), .i_return_instr(ret), .i_stack_done(sd),
        .i_restore_done(rdn), .i_lp_mode(lp), .o_push_regs(push),
        .o_pop_regs(pop), .o_load_vector(load), .o_vector(vec),
        .o_global_mask(mask), .o_wakeup(wake), .o_ext_ack(ack));
    cic_seq_model i_seq (.i_clk(clk), .i_reset_n(rst_n),
        .i_push_regs(push), .i_pop_regs(pop), .i_slow(slow),
        .o_stack_done(sd), .o_restore_done(rdn));

    always @(posedge clk) begin
        if (load === 1'b1) begin
            n_load <= n_load + 1;
            last_vec <= vec;
        end
    end
    task chk(input [31:0] g, input [31:0] e);
        checked = checked + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task bw(input [7:0] idx, input [7:0] d);
        @(posedge clk);
        adr <= {idx, 2'b00};
        wd <= {24'h0, d};
        wr_en <= 1'b1;
        do @(posedge clk); while (wreq !== 1'b0);
        wr_en <= 1'b0;
    endtask
    task br(input [7:0] idx, input [31:0] e);
        @(posedge clk);
        adr <= {idx, 2'b00};
        rd <= 1'b1;
        do @(posedge clk); while (wreq !== 1'b0);
        chk(rdata, e);
        rd <= 1'b0;
    endtask
    // Instruction boundary; if entered, check vector and return
    task take(input e, input [15:0] v);
        integer n0, k;
        n0 = n_load;
        @(posedge clk) ie <= 1'b1;
        @(posedge clk) ie <= 1'b0;
        for (k = 0; k < 40 && n_load == n0; k = k + 1) @(negedge clk);
        chk(n_load - n0, {31'h0, e});
        if (e && n_load != n0) begin
            chk(last_vec, v);
            chk(mask, 1'b1);
            @(posedge clk) ret <= 1'b1;
            @(posedge clk) ret <= 1'b0;
            for (k = 0; k < 40 && (pop || mask); k = k + 1) @(negedge clk);
            chk(mask, 1'b0);
        end
    endtask
    task edg(input [1:0] s, input r, input e);
        bw(`CIC_IDX_CTRL, 8'h04);
        lvl[0] <= ~r;
        bw(`CIC_IDX_SENSE_A, {6'h0, ~s});
        bw(`CIC_IDX_SENSE_A, {6'h0, s});
        lvl[0] <= r;
        repeat (3) @(posedge clk);
        bw(`CIC_IDX_CTRL, 8'h08);
        take(e, `CIC_VEC_EXT0);
    endtask
    task end_sim;
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #100000;
        n_errors = n_errors + 1;
        end_sim;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(mask, 1'b1);
        chk(vec, `CIC_VEC_RESET);
        br(`CIC_IDX_SENSE_A, `CIC_SENSE_A_RESET);
        br(`CIC_IDX_SENSE_B, `CIC_SENSE_B_RESET);
        bw(`CIC_IDX_SENSE_A, 8'hff);
        br(`CIC_IDX_SENSE_A, `CIC_SENSE_A_MASK);
        bw(`CIC_IDX_SENSE_B, 8'hff);
        br(`CIC_IDX_SENSE_B, `CIC_SENSE_B_MASK);
        br(8'h10, 32'h0);
        bw(`CIC_IDX_SENSE_B, 8'h00);
        edg(2'h1, 1'b1, 1'b1);
        edg(2'h1, 1'b0, 1'b0);
        edg(2'h2, 1'b1, 1'b0);
        edg(2'h2, 1'b0, 1'b1);
        edg(2'h3, 1'b1, 1'b1);
        edg(2'h3, 1'b0, 1'b1);
        edg(2'h0, 1'b0, 1'b1);
        take(1'b1, `CIC_VEC_EXT0);
        @(posedge clk) lvl[0] <= 1'b1;
        bw(`CIC_IDX_CTRL, 8'h04);
        bw(`CIC_IDX_SENSE_A, 8'h04);
        bw(`CIC_IDX_SENSE_B, 8'h01);
        @(posedge clk) lvl <= 5'h15;
        @(posedge clk) lvl <= 5'h1f;
        take(1'b0, 16'h0);
        bw(`CIC_IDX_CTRL, 8'h08);
        take(1'b1, `CIC_VEC_EXT1);
        take(1'b1, `CIC_VEC_EXT3);
        bw(`CIC_IDX_SENSE_A, 8'h2a);
        br(`CIC_IDX_SENSE_A, 32'h04);
        bw(`CIC_IDX_CTRL, 8'h04);
        bw(`CIC_IDX_SENSE_A, 8'h14);
        @(posedge clk) lvl[2] <= 1'b0;
        @(posedge clk) lvl[2] <= 1'b1;
        bw(`CIC_IDX_SENSE_A, 8'h34);
        bw(`CIC_IDX_CTRL, 8'h08);
        take(1'b0, 16'h0);
        bw(`CIC_IDX_CTRL, 8'h04);
        bw(`CIC_IDX_SENSE_B, 8'h05);
        @(posedge clk) blk_n[4] <= 1'b0;
        @(posedge clk) lvl[4] <= 1'b0;
        @(posedge clk) lvl[4] <= 1'b1;
        bw(`CIC_IDX_CTRL, 8'h08);
        take(1'b0, 16'h0);
        bw(`CIC_IDX_CTRL, 8'h04);
        @(posedge clk) blk_n <= 5'h1f;
        bw(`CIC_IDX_SENSE_B, 8'h01);
        @(posedge clk) trap <= 1'b1;
        @(posedge clk) trap <= 1'b0;
        take(1'b1, `CIC_VEC_TRAP);
        bw(`CIC_IDX_CTRL, 8'h01);
        take(1'b1, `CIC_VEC_TRAP);
        br(`CIC_IDX_VECTOR, {16'h0, `CIC_VEC_TRAP});
        br(`CIC_IDX_CTRL, 32'h0);
        @(posedge clk) slow <= 1'b1;
        @(posedge clk) flag <= 5'h02;
        take(1'b0, 16'h0);
        for (i = 0; i < 5; i = i + 1) begin
            @(posedge clk) ena <= 5'h1f;
            flag <= 5'h01 << i;
            take(1'b1, pv[i]);
            @(posedge clk) flag <= 5'h0;
        end
        take(1'b0, 16'h0);
        bw(`CIC_IDX_CTRL, 8'h04);
        bw(`CIC_IDX_SENSE_B, 8'h04);
        bw(`CIC_IDX_CTRL, 8'h08);
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk) lp <= md[i];
            flag <= 5'h01 << fi[i];
            repeat (3) @(posedge clk);
            @(negedge clk) chk(wake, ex[i]);
            @(posedge clk) lp <= 3'h0;
            flag <= 5'h0;
            repeat (3) @(posedge clk);
        end
        end_sim;
    end
endmodule // core_interrupt_controller_tb_top
